// ---- dv/sdc_slave_model.sv ----
// serial slave on the select lines: captures mosi, answers on miso
// assumes one select wire, low while any select is active
`timescale 1ns/1ps
module sdc_slave_model #(
	parameter logic [15:0] TXW = 16'hc3a5
) (
	// serial link
	input  wire logic        serial_clock_i,
	input  wire logic        mosi_i,
	input  wire logic        sel_n_i,
	output logic             miso_o,
	// mode and observation
	input  wire logic        idle_i,
	input  wire logic        edge_i,
	input  int               bits_i,
	output logic      [15:0] word_o,
	output int               edges_o
);
	int   idx;
	logic lead;
	initial begin
		miso_o = 1'b0;
		word_o = 16'h0;
		edges_o = 0;
		idx = 0;
	end
	// ----
	// frame start and release
	// ----
	always @(negedge sel_n_i) begin
		word_o = 16'h0;
		edges_o = 0;
		idx = 0;
		if (edge_i) begin
			miso_o = TXW[15];
			idx = 1;
		end
	end
	// released line stops showing the last bit
	always @(posedge sel_n_i) miso_o = ~miso_o;
	// ----
	// shifting
	// ----
	always @(serial_clock_i) begin
		if (!sel_n_i) begin
			lead = (serial_clock_i !== idle_i);
			edges_o = edges_o + 1;
			if (lead == edge_i) begin
				word_o = {word_o[14:0], mosi_i};
			end else begin
				if (idx >= bits_i) idx = 0;
				miso_o = TXW[4'(15 - idx)];
				idx = idx + 1;
			end
		end
	end
endmodule

// ---- dv/testbench.sv ----
// testbench: apb master, dma memory and slave model around sdc_top
// assumes sdc_pkg, the design and the slave model are compiled first
`timescale 1ns/1ps
module testbench;
	import sdc_pkg::*;
	localparam logic [15:0] SLV = 16'hc3a5;
	logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ack = 0, idl = 0, edg = 0, sq = 0, nq = 1;
	logic        sclk, mosi, miso, prdy, perr, req, we, irq;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, daddr;
	logic [15:0] rdata = 16'h0, wdata, sw, exw;
	logic [3:0]  seln, sv;
	logic [32:0] rq[$];
	logic [31:0] tq[$], xq[$];
	int          n_errors = 0, compares = 0, cyc = 0, tf = 0, t1 = 0, tl = 0, tr = 0, hmin = 0, hmax = 0, se;
	int          nbs = 8;
	sdc_top sdc_top_i (
		.ref_clk_i(clk), .reset_i(rst), .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(prdy), .pslverr_o(perr), .dma_req_o(req), .dma_we_o(we),
		.dma_addr_o(daddr), .dma_wdata_o(wdata), .dma_rdata_i(rdata), .dma_ack_i(ack), .serial_clock_o(sclk),
		.mosi_o(mosi), .miso_i(miso), .peripheral_select_n_o(seln), .irq_o(irq));
	sdc_slave_model #(.TXW(SLV)) sdc_slave_model_i (.serial_clock_i(sclk), .mosi_i(mosi), .sel_n_i(&seln),
		.miso_o(miso), .idle_i(idl), .edge_i(edg), .bits_i(nbs), .word_o(sw), .edges_o(se));
	initial begin
		forever #4 clk = ~clk;
	end
	// ----
	// checks and bus tasks
	// ----
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk_n(input string nm, input int e, input int g);
		compares++;
		if (g != e) begin
			n_errors++;
			$display("mismatch %s exp %0d got %0d", nm, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic bad;
		n_errors++;
		$display("mismatch wait exp done got timeout");
		wrap_up;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 20);
		if (n >= 20) bad;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// ----
	// monitors and memory
	// ----
	always @(posedge clk) begin
		if (psel && penable && prdy === 1'b1 && !pwrite) chk("read", rq.pop_front(), {perr, prdata});
	end
	always @(posedge clk) begin
		ack <= req && !ack && ($urandom % 3 == 0);
		rdata <= 16'($urandom);
		if (req === 1'b1 && ack && we) begin
			chk("rx addr", {1'b0, xq.pop_front()}, {1'b0, daddr});
			chk("rx word", {17'h0, exw}, {17'h0, wdata});
		end
		if (req === 1'b1 && ack && !we) chk("tx addr", {1'b0, tq.pop_front()}, {1'b0, daddr});
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		sq <= sclk;
		nq <= &seln;
		if (nq && !(&seln)) begin
			tf <= cyc;
			tl <= 0;
			sv <= seln;
			hmin <= 99999;
			hmax <= 0;
		end else if (sclk !== sq && !(&seln)) begin
			if (tl == 0) t1 <= cyc;
			if (tl != 0 && cyc - tl < hmin) hmin <= cyc - tl;
			if (tl != 0 && cyc - tl > hmax) hmax <= cyc - tl;
			tl <= cyc;
		end
		if (!nq && (&seln)) tr <= cyc;
	end
	// ----
	// one framed transfer and its checks
	// ----
	task automatic xfer(input logic [1:0] s, input logic [15:0] w, input logic [31:0] cf, input logic p, input logic ld);
		int nb, tk, n, t0;
		nb = 8 + int'(cf[7:4]);
		nbs = nb;
		tk = p ? 32 : 1;
		t0 = cyc;
		idl = cf[0];
		edg = cf[1];
		wr(8'h30 + {4'h0, s, 2'h0}, cf);
		if (ld) begin
			wr(8'h00, {22'h0, s, 6'h0, p, 1'b1});
			wr(8'h08, {16'h0, w});
		end
		n = 0;
		while (tr <= t0 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000) bad;
		repeat (2) @(posedge clk);
		if (!p) chk_n("lead", cf[23:16] == 8'h0 ? int'(cf[15:8]) : int'(cf[23:16]), t1 - tf);
		chk_n("half", int'(cf[15:8]) * tk, hmin);
		chk_n("half max", int'(cf[15:8]) * tk, hmax);
		chk_n("edges", 2 * nb, se);
		chk_n("gap", 1, int'(tr - tl >= (cf[31:24] == 8'h0 ? 4 : 32 * int'(cf[31:24])) * tk));
		chk("idle", {32'h0, cf[0]}, {32'h0, sclk});
		chk("select", {29'h0, ~(4'h1 << s)}, {29'h0, sv});
		chk("word", {17'h0, w & (16'hffff >> (16 - nb))}, {17'h0, sw});
		rd(8'h0c, {17'h0, SLV >> (16 - nb)});
		$display("transfer on select %0d done", s);
	endtask
	initial begin : main
		logic [31:0] c;
		logic [31:0] cfs [4];
		logic [15:0] w;
		int n, nb0;
		n = $urandom(32'h7aaf);
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (n = 8; n < 16; n++) rd(8'(n * 4), 33'h0);
		rd(8'h40, 33'h1_0000_0000);
		$display("reset values done");
		for (n = 8; n < 16; n++) begin
			c = $urandom;
			if (n == 9 || n == 11) c[31:16] = 16'h0;
			if (n > 11) c[3:2] = 2'h0;
			wr(8'(n * 4), c);
			rd(8'(n * 4), {1'b0, c});
		end
		wr(8'h24, 32'h0);
		wr(8'h2c, 32'h0);
		$display("register access done");
		nb0 = 8 + int'($urandom % 9);
		cfs = '{{16'h0, 8'h02, 4'(nb0 - 8), 4'h0}, 32'h0000_ff01, 32'h0000_0232, 32'h0105_0383};
		for (n = 0; n < 4; n++) wr(8'h30 + 8'(n * 4), cfs[n]);
		w = 16'($urandom);
		wr(8'h30, 32'h0000_0100);
		wr(8'h00, 32'h1);
		wr(8'h08, {16'h0, w});
		repeat (100) @(posedge clk);
		chk_n("no select", 0, tf);
		chk("stopped clock", 33'h0, {32'h0, sclk});
		xfer(2'd0, w, cfs[0], 1'b0, 1'b0);
		for (n = 1; n < 4; n++) xfer(2'(n), 16'($urandom), cfs[n], n == 2, 1'b1);
		exw = SLV >> (16 - nb0);
		nbs = nb0;
		idl = 1'b0;
		edg = 1'b0;
		c = ($urandom & 32'h00fffff0) | 32'h100;
		tq = '{c, c + 32'h2};
		xq = '{c + 32'h1000, c + 32'h1002};
		wr(8'h00, 32'h1);
		wr(8'h18, 32'h10);
		wr(8'h28, c);
		wr(8'h20, c + 32'h1000);
		wr(8'h24, 32'h2);
		wr(8'h2c, 32'h2);
		n = 0;
		while (irq !== 1'b1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000) bad;
		repeat (20) @(posedge clk);
		rd(8'h24, 33'h0);
		rd(8'h2c, 33'h0);
		rd(8'h20, {1'b0, c + 32'h1004});
		rd(8'h28, {1'b0, c + 32'h4});
		rd(8'h04, 33'h32);
		wr(8'h18, 32'h0);
		repeat (3) @(posedge clk);
		chk("irq masked", 33'h0, {32'h0, irq});
		wr(8'h18, 32'h10);
		repeat (3) @(posedge clk);
		chk("irq enabled", 33'h1, {32'h0, irq});
		wr(8'h14, 32'h30);
		repeat (200) @(posedge clk);
		chk("irq cleared", 33'h0, {32'h0, irq});
		chk_n("dma left", 0, tq.size() + xq.size());
		$display("dma and interrupt done");
		wrap_up;
	end
endmodule

// ---- hdl/sdc_cfg_if.sv ----
// bundle between the block and its select configuration store
// assumes one writer and two registered readers
`timescale 1ns/1ps
interface sdc_cfg_if;
	import sdc_pkg::*;
	logic                 we;
	logic [CFG_IDX_W-1:0] waddr;
	logic [31:0]          wdata;
	logic [CFG_IDX_W-1:0] raddr_a;
	logic [CFG_IDX_W-1:0] raddr_b;
	logic [31:0]          rdata_a;
	logic [31:0]          rdata_b;
	modport mem (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
	modport user (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
endinterface

// ---- hdl/sdc_cfg_mem.sv ----
// per-select configuration words with registered read ports
// assumes synchronous active high reset on the one clock
`timescale 1ns/1ps
module sdc_cfg_mem
	import sdc_pkg::*;
#(
	parameter int DEPTH = CFG_NUM
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// store access
	sdc_cfg_if.mem   port
);
	logic [31:0] mem_r [DEPTH];

	if (DEPTH != CFG_NUM) begin : g_chk
		$error("depth must match select count");
	end

	for (genvar g = 0; g < DEPTH; g++) begin : g_word
		always_ff @(posedge ref_clk_i) begin
			if (reset_i) begin
				mem_r[g] <= REG_RST;
			end else if (port.we && port.waddr == CFG_IDX_W'(g)) begin
				mem_r[g] <= port.wdata;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			port.rdata_a <= REG_RST;
			port.rdata_b <= REG_RST;
		end else begin
			port.rdata_a <= mem_r[port.raddr_a];
			port.rdata_b <= mem_r[port.raddr_b];
		end
	end
endmodule

// ---- hdl/sdc_pkg.sv ----
// constants for the serial channel block: offsets, fields, reset values
// assumes a 32-bit apb slave and a byte-addressed dma memory port
package sdc_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_FLAGS  = 8'h04;
	localparam logic [7:0] OFS_TXDATA = 8'h08;
	localparam logic [7:0] OFS_RXDATA = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_CLEAR  = 8'h14;
	localparam logic [7:0] OFS_IRQEN  = 8'h18;
	localparam logic [7:0] OFS_RXBUF  = 8'h20;
	localparam logic [7:0] OFS_RXCNT  = 8'h24;
	localparam logic [7:0] OFS_TXBUF  = 8'h28;
	localparam logic [7:0] OFS_TXCNT  = 8'h2c;
	localparam logic [7:0] OFS_CFG0   = 8'h30;
	localparam logic [7:0] OFS_CFG3   = 8'h3c;
	localparam logic [31:0] REG_RST   = 32'h0;
	// ----------------------------------------
	// field layout
	// ----------------------------------------
	localparam int CFG_NUM     = 4;
	localparam int CFG_IDX_W   = 2;
	localparam int CFG_IDLE_B  = 0;
	localparam int CFG_EDGE_B  = 1;
	localparam int CFG_BITS_LO = 4;
	localparam int CFG_BITS_W  = 4;
	localparam int CFG_DIV_LO  = 8;
	localparam int CFG_LEAD_LO = 16;
	localparam int CFG_GAP_LO  = 24;
	localparam int FLD_W       = 8;
	localparam int CTRL_EN_B   = 0;
	localparam int CTRL_P32_B  = 1;
	localparam int CTRL_SEL_LO = 8;
	localparam int EV_W        = 6;
	localparam int EV_RXFULL   = 0;
	localparam int EV_TXEMPTY  = 1;
	localparam int EV_RXDONE   = 4;
	localparam int EV_TXDONE   = 5;
	localparam int FLAG_BUSY   = 8;
	localparam int WORD_W      = 16;
	// ----------------------------------------
	// timing and word constants
	// ----------------------------------------
	localparam logic [4:0] BITS_MIN      = 5'h08;
	localparam logic [3:0] BITS_CODE_MAX = 4'h8;
	localparam logic [7:0] DIV_MIN       = 8'h02;
	localparam logic [4:0] PRESCALE_LAST = 5'h1f;
	localparam logic [15:0] GAP_ZERO     = 16'h0004;
	localparam logic [15:0] GAP_MULT     = 16'h0020;
	localparam logic [31:0] PTR_STEP     = 32'h2;
	typedef enum logic [1:0] {
		SDC_IDLE,
		SDC_LEAD,
		SDC_SHIFT,
		SDC_GAP
	} sdc_state_e;
endpackage

// ---- hdl/sdc_top.sv ----
// serial master with receive/transmit dma channels and select configs
// assumes apb master, a dma memory port with ack, synchronous inputs
//
// Summary of operation
// RL1: software sets receive buffer start address first
// RL2: receive count zero stops; nonzero moves full words
// RL3: software sets transmit buffer start address first
// RL4: transmit count zero stops; nonzero fills empty holding
// RL5: idle bit sets serial clock idle level
// RL6: sample-edge bit picks change versus capture edge
// RL7: length code 0..8 gives 8..16 bits
// RL8: software avoids reserved length codes 9..15
// RL9: serial clock is main clock over twice divisor
// RL10: divisor fed by main clock or main/32
// RL11: divisor below two disables, clock idles
// RL12: zero lead delay means half serial period
// RL13: nonzero lead delay is field main periods
// RL14: zero gap delay means four main periods
// RL15: gap always inserted, else 32 times field
// RL16: channel done flags shown while count zero
// RL17: receive full set when word lands
// RL18: each move steps pointer, decrements count
// RL19: each select uses its own config word
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module sdc_top
	import sdc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              reset_i,
	// apb slave
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// dma memory port
	output logic                   dma_req_o,
	output logic                   dma_we_o,
	output logic      [31:0]       dma_addr_o,
	output logic      [WORD_W-1:0] dma_wdata_o,
	input  wire logic [WORD_W-1:0] dma_rdata_i,
	input  wire logic              dma_ack_i,
	// serial link
	output logic                   serial_clock_o,
	output logic                   mosi_o,
	input  wire logic              miso_i,
	output logic      [CFG_NUM-1:0] peripheral_select_n_o,
	// interrupt
	output logic                   irq_o
);
	if (ADDR_W < 8) begin : g_chk
		$error("address must reach all registers");
	end

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic [4:0] bits_of(input logic [31:0] c);
		logic [3:0] k;
		k = c[CFG_BITS_LO +: CFG_BITS_W];
		if (k > BITS_CODE_MAX)
			k = BITS_CODE_MAX;
		return BITS_MIN + 5'(k);
	endfunction

	function automatic logic div_ok(input logic [31:0] c);
		return c[CFG_DIV_LO +: FLD_W] >= DIV_MIN;
	endfunction

	function automatic logic [WORD_W-1:0] align(input logic [WORD_W-1:0] w,
						    input logic [31:0] c);
		return w << (5'(WORD_W) - bits_of(c));
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	sdc_cfg_if cfg ();
	logic [31:0]        ctrl_r;
	logic [31:0]        irqen_r;
	logic [31:0]        rx_ptr_r;
	logic [31:0]        tx_ptr_r;
	logic [15:0]        rx_cnt_r;
	logic [15:0]        tx_cnt_r;
	logic [WORD_W-1:0]  tx_hold_r;
	logic [WORD_W-1:0]  rx_data_r;
	logic [WORD_W-1:0]  sh_r;
	logic [WORD_W-1:0]  rx_sh_r;
	logic               tx_full_r;
	logic               rx_full_r;
	logic [EV_W-1:0]    stat_r;
	logic [4:0]         pre_cnt_r;
	logic [CFG_IDX_W-1:0] sel_q_r;
	sdc_state_e         st_r;
	logic [15:0]        dly_r;
	logic [7:0]         baud_r;
	logic [5:0]         edge_r;
	logic [31:0]        act_cfg_r;
	logic [CFG_IDX_W-1:0] act_sel_r;

	sdc_cfg_mem u_cfg (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.port      (cfg.mem)
	);

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire [7:0]  ofs    = paddr_i[7:0];
	wire        acc    = psel_i & penable_i;
	wire        rd_cyc = acc & ~pready_o;
	wire        wr_en  = acc & pready_o & pwrite_i;
	wire        rd_end = acc & pready_o & ~pwrite_i;
	wire        is_cfg = ofs >= OFS_CFG0 && ofs <= OFS_CFG3 && ofs[1:0] == 2'h0;
	wire        hit    = is_cfg || ofs == OFS_CTRL || ofs == OFS_FLAGS ||
			     ofs == OFS_TXDATA || ofs == OFS_RXDATA ||
			     ofs == OFS_STATUS || ofs == OFS_CLEAR ||
			     ofs == OFS_IRQEN || ofs == OFS_RXBUF ||
			     ofs == OFS_RXCNT || ofs == OFS_TXBUF ||
			     ofs == OFS_TXCNT;
	wire        w_ctrl = wr_en && ofs == OFS_CTRL;
	wire        w_tx   = wr_en && ofs == OFS_TXDATA;
	wire        w_clr  = wr_en && ofs == OFS_CLEAR;
	wire        w_ien  = wr_en && ofs == OFS_IRQEN;
	wire        w_rxp  = wr_en && ofs == OFS_RXBUF;
	wire        w_rxc  = wr_en && ofs == OFS_RXCNT;
	wire        w_txp  = wr_en && ofs == OFS_TXBUF;
	wire        w_txc  = wr_en && ofs == OFS_TXCNT;
	wire        r_rx   = rd_end && ofs == OFS_RXDATA;
	wire        en     = ctrl_r[CTRL_EN_B];
	wire [CFG_IDX_W-1:0] sel = ctrl_r[CTRL_SEL_LO +: CFG_IDX_W];

	assign cfg.we      = wr_en & is_cfg;
	assign cfg.waddr   = ofs[2 +: CFG_IDX_W];
	assign cfg.wdata   = pwdata_i;
	assign cfg.raddr_a = ofs[2 +: CFG_IDX_W];
	assign cfg.raddr_b = sel; // RL19

	wire [31:0] flags = {23'h0, st_r != SDC_IDLE, 2'h0,
			     tx_cnt_r == 16'h0, rx_cnt_r == 16'h0, 2'h0,
			     en & ~tx_full_r, rx_full_r}; // RL16
	wire [31:0] rd_mux =
		is_cfg              ? cfg.rdata_a :
		ofs == OFS_CTRL     ? ctrl_r :
		ofs == OFS_FLAGS    ? flags :
		ofs == OFS_RXDATA   ? {16'h0, rx_data_r} :
		ofs == OFS_STATUS   ? {26'h0, stat_r} :
		ofs == OFS_IRQEN    ? irqen_r :
		ofs == OFS_RXBUF    ? rx_ptr_r :
		ofs == OFS_RXCNT    ? {16'h0, rx_cnt_r} :
		ofs == OFS_TXBUF    ? tx_ptr_r :
		ofs == OFS_TXCNT    ? {16'h0, tx_cnt_r} : REG_RST;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= REG_RST;
		end else begin
			pready_o  <= rd_cyc;
			pslverr_o <= rd_cyc & ~hit;
			prdata_o  <= rd_cyc ? rd_mux : REG_RST;
		end
	end

	// ----------------------------------------
	// clock prescale and config view
	// ----------------------------------------
	wire        pre_tick = ~ctrl_r[CTRL_P32_B] | pre_cnt_r == PRESCALE_LAST; // RL10
	wire [31:0] cfg_b    = cfg.rdata_b;
	wire        go       = en & tx_full_r & sel_q_r == sel & div_ok(cfg_b); // RL11
	wire [7:0]  a_div    = act_cfg_r[CFG_DIV_LO +: FLD_W];
	wire [7:0]  a_gap    = act_cfg_r[CFG_GAP_LO +: FLD_W];
	wire [7:0]  b_lead   = cfg_b[CFG_LEAD_LO +: FLD_W];
	wire        a_phase  = act_cfg_r[CFG_EDGE_B];
	wire        a_idle   = act_cfg_r[CFG_IDLE_B];
	wire [15:0] lead_ld  = b_lead == 8'h0 ? {8'h0, cfg_b[CFG_DIV_LO +: FLD_W]}
					      : {8'h0, b_lead}; // RL12 RL13
	wire [15:0] gap_ld   = a_gap == 8'h0 ? GAP_ZERO
					     : 16'({8'h0, a_gap} * GAP_MULT); // RL14 RL15
	wire [5:0]  edges_ld = {bits_of(act_cfg_r), 1'b0}; // RL7
	wire        dly_end  = pre_tick & dly_r == 16'h1;
	wire        baud_end = (st_r == SDC_SHIFT & pre_tick & baud_r == 8'h1) |
			       (st_r == SDC_LEAD & dly_end); // RL9 RL12
	wire        lead_e   = st_r == SDC_LEAD | ~edge_r[0];
	wire        samp     = baud_end & (lead_e == a_phase); // RL6
	wire        chg      = baud_end & ~samp;
	wire        word_end = baud_end & st_r == SDC_SHIFT & edge_r == 6'h1;
	wire        start    = st_r == SDC_IDLE & go;
	wire        restart  = st_r == SDC_GAP & dly_end & go &
			       cfg_b == act_cfg_r & sel == act_sel_r;
	wire        load     = start | restart;
	wire        release_sel = st_r == SDC_GAP & dly_end & ~restart;
	wire [WORD_W-1:0] al = align(tx_hold_r, cfg_b);
	wire [WORD_W-1:0] rx_sh_nxt = {rx_sh_r[WORD_W-2:0], miso_i};
	wire [WORD_W-1:0] rx_word   = samp ? rx_sh_nxt : rx_sh_r;
	wire        sel_on   = start | (st_r != SDC_IDLE & ~release_sel);
	wire [CFG_IDX_W-1:0] sel_idx = start ? sel : act_sel_r;
	logic [CFG_NUM-1:0] sel_n_nxt;

	for (genvar g = 0; g < CFG_NUM; g++) begin : g_sel
		assign sel_n_nxt[g] = ~(sel_on && sel_idx == CFG_IDX_W'(g));
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			pre_cnt_r <= 5'h0;
			sel_q_r   <= '0;
			peripheral_select_n_o <= '1;
		end else begin
			pre_cnt_r <= pre_cnt_r + 5'h1;
			sel_q_r   <= sel;
			peripheral_select_n_o <= sel_n_nxt; // RL15
		end
	end

	// ----------------------------------------
	// transfer sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			st_r      <= SDC_IDLE;
			dly_r     <= 16'h0;
			baud_r    <= 8'h0;
			edge_r    <= 6'h0;
			act_cfg_r <= REG_RST;
			act_sel_r <= '0;
			serial_clock_o <= 1'b0;
		end else begin
			case (st_r)
			SDC_IDLE: begin
				serial_clock_o <= cfg_b[CFG_IDLE_B]; // RL5 RL11
				if (start) begin
					st_r      <= SDC_LEAD;
					dly_r     <= lead_ld;
					act_cfg_r <= cfg_b; // RL19
					act_sel_r <= sel;
				end
			end
			SDC_LEAD: begin
				if (dly_end) begin
					st_r   <= SDC_SHIFT;
					serial_clock_o <= ~serial_clock_o; // RL12 RL13
					baud_r <= a_div;
					edge_r <= edges_ld - 6'h1;
				end else if (pre_tick) begin
					dly_r <= dly_r - 16'h1;
				end
			end
			SDC_SHIFT: begin
				if (baud_end) begin
					serial_clock_o <= ~serial_clock_o;
					baud_r <= a_div;
					edge_r <= edge_r - 6'h1;
					if (word_end) begin
						st_r  <= SDC_GAP;
						dly_r <= gap_ld;
					end
				end else if (pre_tick) begin
					baud_r <= baud_r - 8'h1;
				end
			end
			SDC_GAP: begin
				if (restart) begin
					st_r   <= SDC_SHIFT;
					baud_r <= a_div;
					edge_r <= edges_ld;
				end else if (dly_end) begin
					st_r <= SDC_IDLE;
				end else if (pre_tick) begin
					dly_r <= dly_r - 16'h1;
				end
			end
			default: st_r <= SDC_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			sh_r    <= '0;
			rx_sh_r <= '0;
			mosi_o  <= 1'b0;
		end else if (load) begin
			rx_sh_r <= '0;
			sh_r    <= cfg_b[CFG_EDGE_B] ? al << 1 : al;
			mosi_o  <= cfg_b[CFG_EDGE_B] ? al[WORD_W-1] : mosi_o; // RL6
		end else begin
			if (chg) begin
				mosi_o <= sh_r[WORD_W-1];
				sh_r   <= sh_r << 1;
			end
			if (samp)
				rx_sh_r <= rx_sh_nxt;
		end
	end

	// ----------------------------------------
	// dma channels
	// ----------------------------------------
	wire ack_rx = dma_req_o & dma_ack_i & dma_we_o;
	wire ack_tx = dma_req_o & dma_ack_i & ~dma_we_o;
	wire rx_go  = en & rx_full_r & rx_cnt_r != 16'h0 & ~dma_req_o; // RL2
	wire tx_go  = en & ~tx_full_r & tx_cnt_r != 16'h0 & ~dma_req_o & ~rx_go; // RL4
	wire [EV_W-1:0] ev;
	wire [EV_W-1:0] stat_nxt;

	assign ev[EV_RXFULL]  = word_end;
	assign ev[EV_TXEMPTY] = load;
	assign ev[3:2]        = 2'h0;
	assign ev[EV_RXDONE]  = ack_rx & rx_cnt_r == 16'h1;
	assign ev[EV_TXDONE]  = ack_tx & tx_cnt_r == 16'h1;
	assign stat_nxt = ev | (stat_r & ~(w_clr ? pwdata_i[EV_W-1:0] : '0));

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			dma_req_o   <= 1'b0;
			dma_we_o    <= 1'b0;
			dma_addr_o  <= REG_RST;
			dma_wdata_o <= '0;
		end else if (rx_go) begin
			dma_req_o   <= 1'b1;
			dma_we_o    <= 1'b1;
			dma_addr_o  <= rx_ptr_r; // RL1
			dma_wdata_o <= rx_data_r;
		end else if (tx_go) begin
			dma_req_o  <= 1'b1;
			dma_we_o   <= 1'b0;
			dma_addr_o <= tx_ptr_r; // RL3
		end else if (dma_ack_i) begin
			dma_req_o <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			rx_ptr_r <= REG_RST;
			tx_ptr_r <= REG_RST;
			rx_cnt_r <= 16'h0;
			tx_cnt_r <= 16'h0;
		end else begin
			rx_ptr_r <= w_rxp ? pwdata_i : ack_rx ? rx_ptr_r + PTR_STEP : rx_ptr_r; // RL18
			tx_ptr_r <= w_txp ? pwdata_i : ack_tx ? tx_ptr_r + PTR_STEP : tx_ptr_r; // RL18
			rx_cnt_r <= w_rxc ? pwdata_i[15:0] : ack_rx ? rx_cnt_r - 16'h1 : rx_cnt_r;
			tx_cnt_r <= w_txc ? pwdata_i[15:0] : ack_tx ? tx_cnt_r - 16'h1 : tx_cnt_r;
		end
	end

	// ----------------------------------------
	// data holding, flags, interrupt
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ctrl_r    <= REG_RST;
			irqen_r   <= REG_RST;
			tx_hold_r <= '0;
			rx_data_r <= '0;
			tx_full_r <= 1'b0;
			rx_full_r <= 1'b0;
			stat_r    <= '0;
			irq_o     <= 1'b0;
		end else begin
			ctrl_r    <= w_ctrl ? pwdata_i : ctrl_r;
			irqen_r   <= w_ien ? {26'h0, pwdata_i[EV_W-1:0]} : irqen_r;
			tx_hold_r <= w_tx ? pwdata_i[WORD_W-1:0] : ack_tx ? dma_rdata_i : tx_hold_r;
			rx_data_r <= word_end ? rx_word : rx_data_r;
			tx_full_r <= w_tx | ack_tx | (tx_full_r & ~load);
			rx_full_r <= word_end | (rx_full_r & ~(ack_rx | r_rx)); // RL17
			stat_r    <= stat_nxt;
			irq_o     <= |(stat_nxt & irqen_r[EV_W-1:0]);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	idle_level_a: assert property (st_r == SDC_IDLE && $past(st_r) == SDC_IDLE |-> serial_clock_o == $past(cfg_b[CFG_IDLE_B])) // RL5
		else $error("clock not at idle level");
	edge_kind_a: assert property ($changed(mosi_o) && $past(st_r) == SDC_SHIFT |-> $changed(serial_clock_o) && ((serial_clock_o != a_idle) != a_phase)) // RL6
		else $error("data changed on wrong edge");
	word_len_a: assert property (st_r == SDC_SHIFT && $past(st_r) == SDC_LEAD |-> // RL7
		edge_r == {bits_of(act_cfg_r), 1'b0} - 6'h1)
		else $error("wrong bit count");
	half_period_a: assert property ($changed(serial_clock_o) && st_r == SDC_SHIFT |=> $stable(serial_clock_o)) // RL9
		else $error("serial clock too fast");
	prescale_a: assert property (ctrl_r[CTRL_P32_B] && $past(ctrl_r[CTRL_P32_B]) && pre_tick |=> !pre_tick [*8]) // RL10
		else $error("prescale tick too early");
	baud_off_a: assert property (st_r == SDC_IDLE && !div_ok(cfg_b) |=> st_r == SDC_IDLE) // RL11
		else $error("transfer with divisor off");
	lead_a: assert property (st_r == SDC_LEAD && $past(st_r) == SDC_IDLE |-> dly_r == (act_cfg_r[CFG_LEAD_LO +: FLD_W] == 8'h0 ? {8'h0, a_div} : {8'h0, act_cfg_r[CFG_LEAD_LO +: FLD_W]})) // RL12 RL13
		else $error("wrong lead delay");
	gap_a: assert property (st_r == SDC_GAP && $past(st_r) == SDC_SHIFT |-> dly_r == (a_gap == 8'h0 ? 16'h4 : {3'h0, a_gap, 5'h0})) // RL14 RL15
		else $error("wrong gap delay");
	gap_sel_a: assert property (st_r == SDC_GAP |-> peripheral_select_n_o != '1) // RL15
		else $error("select dropped in gap");
	rx_stop_a: assert property (dma_req_o && dma_we_o && $rose(dma_req_o) |-> $past(rx_cnt_r) != 16'h0) // RL2
		else $error("receive move with zero count");
	tx_stop_a: assert property (dma_req_o && !dma_we_o && $rose(dma_req_o) |-> $past(tx_cnt_r) != 16'h0) // RL4
		else $error("transmit move with zero count");
	rx_step_a: assert property (ack_rx && !w_rxp && !w_rxc |=> rx_ptr_r == $past(rx_ptr_r) + 32'h2 && rx_cnt_r == $past(rx_cnt_r) - 16'h1) // RL18
		else $error("receive pointer step wrong");
	rx_full_a: assert property (word_end |=> rx_full_r && rx_data_r == $past(rx_word)) // RL17
		else $error("receive full not set");
	done_flag_a: assert property (flags[EV_RXDONE] == (rx_cnt_r == 16'h0)) // RL16
		else $error("done flag wrong");

	word_c: cover property (word_end);
	back_c: cover property (restart);
	rx_move_c: cover property (ack_rx && rx_cnt_r == 16'h1);
	tx_move_c: cover property (ack_tx);
endmodule
